// [src/sleep_ctrl_cfg.svh]
// constants for the sleep-mode controller: offsets, fields, reset values, timing
`ifndef SLEEP_CTRL_CFG_SVH
`define SLEEP_CTRL_CFG_SVH
`define SC_ADDR_CTRL 4'h0
`define SC_ADDR_STATUS 4'h1
`define SC_ADDR_CFG 4'h2
`define SC_CTRL_RESET 8'h00
`define SC_CFG_RESET 8'h00
`define SC_ARM_BIT 7
`define SC_SEL_HI 6
`define SC_SEL_LO 4
`define SC_CFG_XTAL_BIT 0
`define SC_CFG_ASYNC_BIT 1
`define SC_CFG_ADC_EN_BIT 2
`define SC_CFG_GIE_BIT 3
`define SC_CFG_T2IE_BIT 4
`define SC_CFG_SUT_HI 7
`define SC_CFG_SUT_LO 5
`define SC_HALT_EXTRA 8'h04
`define SC_STANDBY_WAKE 8'h06
`define SC_PD_WAKE_BASE 8'h06
`define SC_IDLE_WAKE 8'h00
`endif

// [src/sleep_ctrl_pkg.sv]
// types shared by the sleep-mode controller files
package sleep_ctrl_pkg;
   typedef enum logic [2:0] {
      MODE_IDLE = 3'b000,
      MODE_NOISE = 3'b001,
      MODE_PDOWN = 3'b010,
      MODE_PSAVE = 3'b011,
      MODE_RSV4 = 3'b100,
      MODE_RSV5 = 3'b101,
      MODE_STANDBY = 3'b110,
      MODE_EXT_STANDBY = 3'b111
   } sleep_mode_t;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_SLEEP = 2'b01,
      ST_WAKE = 2'b10
   } sleep_state_t;

   // clock domain gates, 1 = clock runs
   typedef struct packed {
      logic core_clock_domain;
      logic program_memory_clock;
      logic peripheral_io_clock;
      logic adc_clock;
      logic async_clock;
      logic main_osc;
   } clk_gates_t;

   // wake sources seen by the controller
   typedef struct packed {
      logic ext_reset;
      logic wdt_reset;
      logic bod_reset;
      logic twi_match;
      logic ext_irq_line2;
      logic ext_irq_line1_level;
      logic ext_irq_line0_level;
      logic ext_irq_edge;
      logic timer2_irq;
      logic adc_done;
      logic nvm_ready;
      logic other_irq;
   } wake_src_t;
endpackage

// [src/sleep_mode_controller.sv]
// sleep-mode controller top: control register, sleep state machine, clock gates
//
// Overview of operation
// - sleep needs arm bit set plus halt
// - 3-bit select field picks the mode
// - interrupt wakes; halt four cycles past start-up
// - wake keeps registers and memory intact
// - reset during sleep restarts from reset vector
// - control register layout; all RW, reset zero
// - idle stops core and program clocks only
// - idle wakes on external and internal interrupts
// - idle or noise mode starts a conversion
// - noise mode also stops the io clock
// - noise mode wakes on listed sources only
// - power-down stops oscillator and generated clocks
// - power-down wakes on listed sources only
// - power-down wake delayed by start-up setting
// - power-save keeps async timer 2 running
// - standby modes need crystal clock source
// - standby modes keep oscillator, wake six cycles
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "sleep_ctrl_cfg.svh"
module sleep_mode_controller
   import sleep_ctrl_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   // register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // core handshake
   input wire logic halt_exec_i,
   output logic core_hold_o,
   output logic resume_irq_o,
   output logic resume_reset_o,
   // wake sources
   input wire wake_src_t wake_src_i,
   // clock gates and side effects
   output clk_gates_t clk_gates_o,
   output logic adc_start_o,
   output logic [3:0] sense_ctrl_o
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] cfg;
      sleep_state_t st;
      sleep_mode_t mode;
      logic wake_rst;
      logic [7:0] rdata;
      logic hold;
      logic res_irq;
      logic res_rst;
      clk_gates_t gates;
      logic adc_start;
   } top_state_t;

   top_state_t s_q;
   top_state_t s_d;
   clk_gates_t dec_gates;
   logic dec_wake;
   logic delay_load;
   logic [7:0] delay_count;
   logic delay_done;
   sleep_mode_t sel_mode;
   logic any_reset;

   // register read decode, used for read data
   function automatic logic [7:0] read_mux(input logic [3:0] a, input top_state_t s);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         `SC_ADDR_CTRL: v = s.ctrl;
         `SC_ADDR_STATUS: v = {3'b000, s.st, s.mode};
         `SC_ADDR_CFG: v = s.cfg;
         default: v = 8'h00; // unmapped reads as zero
      endcase
      return v;
   endfunction

   // standby codes fall back to no sleep unless the crystal is selected
   function automatic logic mode_allowed(input sleep_mode_t m, input logic xtal);
      logic ok;
      ok = 1'b1;
      if (m == MODE_RSV4 || m == MODE_RSV5) begin
         ok = 1'b0;
      end else if (m == MODE_STANDBY || m == MODE_EXT_STANDBY) begin
         ok = xtal;
      end
      return ok;
   endfunction

   assign sel_mode = sleep_mode_t'(s_q.ctrl[`SC_SEL_HI:`SC_SEL_LO]);
   assign any_reset = wake_src_i.ext_reset | wake_src_i.wdt_reset | wake_src_i.bod_reset;

   sleep_mode_decode u_decode (
      .mode_i(s_q.mode),
      .sleeping_i(s_q.st == ST_SLEEP),
      .timer2_async_select_i(s_q.cfg[`SC_CFG_ASYNC_BIT]),
      .gie_i(s_q.cfg[`SC_CFG_GIE_BIT]),
      .t2ie_i(s_q.cfg[`SC_CFG_T2IE_BIT]),
      .src_i(wake_src_i),
      .gates_o(dec_gates),
      .wake_o(dec_wake)
   );

   // wake delay: start-up per mode plus the fixed halt cycles
   always_comb begin
      delay_load = (s_q.st == ST_SLEEP) && dec_wake;
      unique case (s_q.mode)
         MODE_PDOWN, MODE_PSAVE: begin
            // start-up comes from the clock source setting
            delay_count = `SC_PD_WAKE_BASE + {5'b00000, s_q.cfg[`SC_CFG_SUT_HI:`SC_CFG_SUT_LO]}
               + `SC_HALT_EXTRA;
         end
         MODE_STANDBY, MODE_EXT_STANDBY: begin
            delay_count = `SC_STANDBY_WAKE + `SC_HALT_EXTRA;
         end
         default: begin
            delay_count = `SC_IDLE_WAKE + `SC_HALT_EXTRA;
         end
      endcase
   end

   wake_delay u_delay (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .load_i(delay_load),
      .count_i(delay_count),
      .done_o(delay_done)
   );

   // register port, sleep state machine and registered outputs
   always_comb begin
      s_d = s_q;
      s_d.rdata = 8'h00;
      s_d.res_irq = 1'b0;
      s_d.res_rst = 1'b0;
      s_d.adc_start = 1'b0;
      if (reg_rd_i) begin
         s_d.rdata = read_mux(reg_addr_i, s_q);
      end
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            `SC_ADDR_CTRL: s_d.ctrl = reg_wdata_i; // all bits writable
            `SC_ADDR_CFG: s_d.cfg = reg_wdata_i;
            default: ;
         endcase
      end
      unique case (s_q.st)
         ST_RUN: begin
            // halt without arm, or with a refused code, just continues
            if (halt_exec_i && s_q.ctrl[`SC_ARM_BIT]
                && mode_allowed(sel_mode, s_q.cfg[`SC_CFG_XTAL_BIT])) begin
               s_d.st = ST_SLEEP;
               s_d.mode = sel_mode;
               s_d.hold = 1'b1;
               // conversion kicks off on entry when enabled
               s_d.adc_start = s_q.cfg[`SC_CFG_ADC_EN_BIT]
                  && (sel_mode == MODE_IDLE || sel_mode == MODE_NOISE);
            end
         end
         ST_SLEEP: begin
            if (dec_wake) begin
               s_d.st = ST_WAKE;
               s_d.wake_rst = any_reset; // reset outranks interrupts
            end
         end
         ST_WAKE: begin
            if (delay_done) begin
               s_d.st = ST_RUN;
               s_d.hold = 1'b0;
               // core state untouched; core resumes or restarts
               s_d.res_irq = ~s_q.wake_rst;
               s_d.res_rst = s_q.wake_rst;
            end
         end
         default: s_d.st = ST_RUN;
      endcase
      // gates follow the decoder while asleep, re-open once awake
      s_d.gates = (s_d.st == ST_SLEEP) ? dec_gates : '1;
      if (s_q.st == ST_SLEEP && s_d.st == ST_SLEEP) begin
         s_d.gates = dec_gates;
      end
      if (s_q.st == ST_RUN && s_d.st == ST_SLEEP) begin
         // first sleeping cycle: gates computed from the chosen mode next cycle
         s_d.gates.core_clock_domain = 1'b0;
         s_d.gates.program_memory_clock = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
         s_q.ctrl <= `SC_CTRL_RESET;
         s_q.cfg <= `SC_CFG_RESET;
         s_q.st <= ST_RUN;
         s_q.mode <= MODE_IDLE;
         s_q.gates <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_o = s_q.rdata;
   assign core_hold_o = s_q.hold;
   assign resume_irq_o = s_q.res_irq;
   assign resume_reset_o = s_q.res_rst;
   assign clk_gates_o = s_q.gates;
   assign adc_start_o = s_q.adc_start;
   assign sense_ctrl_o = s_q.ctrl[3:0];
endmodule // sleep_mode_controller

// [src/sleep_mode_decode.sv]
// mode decode: clock gates and permitted wake sources per sleep mode
`timescale 1ns/1ps
`include "sleep_ctrl_cfg.svh"
module sleep_mode_decode
   import sleep_ctrl_pkg::*;
(
   input wire sleep_mode_t mode_i,
   input wire logic sleeping_i,
   input wire logic timer2_async_select_i,
   input wire logic gie_i,
   input wire logic t2ie_i,
   input wire wake_src_t src_i,
   output clk_gates_t gates_o,
   output logic wake_o
);
   logic rst_any;
   logic deep_ok;
   logic t2_ok;

   // resets wake from every mode
   assign rst_any = src_i.ext_reset | src_i.wdt_reset | src_i.bod_reset;
   // only resets, TWI match, line2 or level interrupts on lines 0/1 reach a stopped clock
   assign deep_ok = rst_any | src_i.twi_match | src_i.ext_irq_line2
      | src_i.ext_irq_line0_level | src_i.ext_irq_line1_level;
   assign t2_ok = timer2_async_select_i & t2ie_i & gie_i & src_i.timer2_irq;

   always_comb begin
      gates_o = '1;
      wake_o = 1'b0;
      if (sleeping_i) begin
         unique case (mode_i)
            MODE_IDLE: begin
               gates_o.core_clock_domain = 1'b0;
               gates_o.program_memory_clock = 1'b0;
               wake_o = deep_ok | src_i.ext_irq_edge | src_i.timer2_irq | src_i.adc_done
                  | src_i.nvm_ready | src_i.other_irq;
            end
            MODE_NOISE: begin
               gates_o.core_clock_domain = 1'b0;
               gates_o.program_memory_clock = 1'b0;
               gates_o.peripheral_io_clock = 1'b0;
               wake_o = deep_ok | src_i.adc_done | src_i.timer2_irq | src_i.nvm_ready;
            end
            MODE_PDOWN, MODE_STANDBY: begin
               gates_o = '0;
               gates_o.main_osc = (mode_i == MODE_STANDBY);
               wake_o = deep_ok;
            end
            MODE_PSAVE, MODE_EXT_STANDBY: begin
               gates_o = '0;
               gates_o.async_clock = timer2_async_select_i;
               gates_o.main_osc = (mode_i == MODE_EXT_STANDBY);
               wake_o = deep_ok | t2_ok;
            end
            default: begin
               wake_o = 1'b1; // reserved codes never sleep
            end
         endcase
      end
   end
endmodule // sleep_mode_decode

// [src/wake_delay.sv]
// down counter that times the start-up delay plus halt cycles
`timescale 1ns/1ps
`include "sleep_ctrl_cfg.svh"
module wake_delay
   import sleep_ctrl_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic load_i,
   input wire logic [7:0] count_i,
   output logic done_o
);
   typedef struct packed {
      logic [7:0] cnt;
      logic busy;
   } delay_state_t;

   delay_state_t s_q;
   delay_state_t s_d;

   // load, then count to zero; done is a one-cycle pulse
   always_comb begin
      s_d = s_q;
      done_o = s_q.busy && (s_q.cnt == 8'h01);
      if (load_i) begin
         s_d.cnt = count_i;
         s_d.busy = 1'b1;
      end else if (s_q.busy) begin
         s_d.cnt = s_q.cnt - 8'h01;
         if (s_q.cnt == 8'h01) begin
            s_d.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule // wake_delay

// [testbench/core_model.sv]
// processor core stand-in: issues the halt instruction and records how it woke
`timescale 1ns/1ps
module core_model (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic go_i,
   input wire logic core_hold_i,
   input wire logic resume_irq_i,
   input wire logic resume_reset_i,
   output logic halt_o,
   output logic [1:0] woke_o
);
   // halt is one cycle; a held core cannot execute, so no halt while held
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         halt_o <= 1'b0;
         woke_o <= 2'b00;
      end else begin
         halt_o <= go_i && !core_hold_i;
         if (go_i)
            woke_o <= 2'b00;
         else if (resume_irq_i || resume_reset_i)
            woke_o <= {resume_reset_i, resume_irq_i};
      end
   end
endmodule // core_model

// [testbench/sleep_ctrl_props.sv]
// assertion checker for the sleep-mode controller ports
`timescale 1ns/1ps
module sleep_ctrl_props
   import sleep_ctrl_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic halt_exec_i,
   input wire logic core_hold_o,
   input wire logic resume_irq_o,
   input wire logic resume_reset_o,
   input wire clk_gates_t clk_gates_o,
   input wire logic adc_start_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // entry and exit steps of one sleep
   sequence s_enter;
      $rose(core_hold_o);
   endsequence
   sequence s_resume;
      resume_irq_o || resume_reset_o;
   endsequence
   a_hold_needs_halt: assert property (s_enter |-> $past(halt_exec_i))
      else $error("hold rose without halt");
   a_run_clock_on: assert property (!core_hold_o && !$past(core_hold_o)
      |-> clk_gates_o.core_clock_domain)
      else $error("core clock off while running");
   // checked on the entry cycle itself: a wake seen at once may reopen the gates a cycle later
   a_core_gated: assert property (s_enter |-> !clk_gates_o.core_clock_domain
      && !clk_gates_o.program_memory_clock)
      else $error("core clocks not gated in sleep");
   a_hold_min_len: assert property (s_enter |-> core_hold_o [*5])
      else $error("hold too short");
   a_resume_release: assert property (s_resume |-> $fell(core_hold_o))
      else $error("resume without hold release");
   a_resume_pulse: assert property (s_resume |=> !resume_irq_o && !resume_reset_o)
      else $error("resume longer than a cycle");
   a_resume_onehot: assert property (!(resume_irq_o && resume_reset_o))
      else $error("both resume kinds at once");
   a_resume_clocks: assert property (s_resume |-> clk_gates_o.core_clock_domain)
      else $error("clocks off at resume");
   a_adc_on_entry: assert property ($rose(adc_start_o) |-> core_hold_o)
      else $error("conversion start outside sleep");
   a_rdata_window: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside its cycle");
endmodule // sleep_ctrl_props

// [testbench/testbench.sv]
// self-checking bench for the sleep-mode controller
`timescale 1ns/1ps
`include "sleep_ctrl_cfg.svh"
module testbench;
   import sleep_ctrl_pkg::*;
   logic clk_i, reset_n_i, reg_wr_i, reg_rd_i, halt_exec_i, go;
   logic core_hold_o, resume_irq_o, resume_reset_o, adc_start_o;
   logic [3:0] reg_addr_i, sense_ctrl_o;
   logic [7:0] reg_wdata_i, reg_rdata_o;
   logic [1:0] woke;
   wake_src_t wake_src_i;
   clk_gates_t clk_gates_o;
   int failures, cmp_count, cycles, adc_cnt;
   sleep_mode_controller DUT (.clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .halt_exec_i, .core_hold_o, .resume_irq_o, .resume_reset_o,
      .wake_src_i, .clk_gates_o, .adc_start_o, .sense_ctrl_o);
   core_model core (.clk_i, .reset_n_i, .go_i(go), .core_hold_i(core_hold_o),
      .resume_irq_i(resume_irq_o), .resume_reset_i(resume_reset_o), .halt_o(halt_exec_i),
      .woke_o(woke));
   always #4 clk_i = ~clk_i;
   // cycle ceiling cuts a hang short; conversion starts are counted
   always @(posedge clk_i) begin
      cycles++;
      if (adc_start_o === 1'b1)
         adc_cnt++;
      if (cycles == 20000) begin
         failures++;
         complete_run;
      end
   end
   task automatic complete_run;
      $display("compares %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         failures++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   // each access waits an edge first so a strobe never rises twice in one step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      // read data stand for this one cycle; take them at its closing edge
      @(posedge clk_i);
      d = reg_rdata_o;
   endtask
   // one sleep: refused sources first, then the waking one, delay in edges
   task automatic nap(input string nm, input logic [7:0] c, cf, input wake_src_t bad, good,
      input clk_gates_t g, input int n, input logic [1:0] kind);
      int k;
      logic [7:0] d;
      wr(`SC_ADDR_CFG, cf);
      wr(`SC_ADDR_CTRL, c);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      wake_src_i <= bad;
      repeat (12) @(posedge clk_i);
      chk(core_hold_o === 1'b1, "not asleep or woke early");
      chk(clk_gates_o === g, "gate pattern");
      rd(`SC_ADDR_STATUS, d);
      chk(d === {3'b000, 2'b01, c[6:4]}, "status while asleep");
      k = 0;
      wake_src_i <= good; // level held until the core resumes
      while (woke === 2'b00 && k < 40) begin
         @(posedge clk_i);
         k++;
      end
      wake_src_i <= '0;
      // n + 3: sampling edge, core model register, the edge at which the loop sees woke
      chk(woke === kind && k == n + 3, "wake kind or delay");
      rd(`SC_ADDR_CTRL, d);
      chk(d === c, "ctrl lost over sleep");
      $display("test %s done", nm);
   endtask
   task automatic t_regs;
      logic [7:0] d;
      rd(`SC_ADDR_CTRL, d);
      chk(d === `SC_CTRL_RESET, "ctrl reset value");
      wr(`SC_ADDR_CTRL, 8'h0f);
      rd(`SC_ADDR_CTRL, d);
      chk(d === 8'h0f && sense_ctrl_o === 4'hf, "ctrl write");
      wr(`SC_ADDR_STATUS, 8'hff);
      rd(`SC_ADDR_STATUS, d);
      chk(d === 8'h00, "status written");
      rd(4'h9, d);
      chk(d === 8'h00, "unmapped read");
      $display("test regs done");
   endtask
   // unarmed, both reserved codes, standby without crystal
   task automatic t_refuse;
      logic [7:0] v [4] = '{8'h00, 8'hc0, 8'hd0, 8'he0};
      wr(`SC_ADDR_CFG, 8'h00);
      foreach (v[i]) begin
         wr(`SC_ADDR_CTRL, v[i]);
         go <= 1'b1;
         @(posedge clk_i);
         go <= 1'b0;
         repeat (5) @(posedge clk_i);
         chk(core_hold_o === 1'b0 && clk_gates_o === 6'h3f, "slept when barred");
      end
      $display("test refuse done");
   endtask
   task automatic t_idle;
      nap("idle", 8'h80, 8'h04, '0, 12'h001, 6'h0f, 4, 2'b01);
      chk(adc_cnt === 1, "idle conversion start");
   endtask
   task automatic t_noise;
      nap("noise", 8'h95, 8'h04, 12'h001, 12'h004, 6'h07, 4, 2'b01);
      chk(adc_cnt === 2, "noise conversion start");
   endtask
   task automatic t_pdown;
      nap("pdown", 8'ha0, 8'h20, 12'h019, 12'h100, 6'h00, 11, 2'b01);
   endtask
   task automatic t_psave;
      nap("psave", 8'hb0, 8'h3a, 12'h011, 12'h008, 6'h02, 11, 2'b01);
   endtask
   task automatic t_standby;
      nap("standby", 8'he0, 8'h01, 12'h001, 12'h080, 6'h01, 10, 2'b01);
      nap("ext standby", 8'hf0, 8'h03, 12'h001, 12'h040, 6'h03, 10, 2'b01);
   endtask
   task automatic t_reset_wake;
      nap("reset wake", 8'h80, 8'h00, '0, 12'h800, 6'h0f, 4, 2'b10);
      chk(adc_cnt === 2, "conversion start while disabled");
   endtask
   initial begin
      clk_i = 1'b0;
      reset_n_i = 1'b0;
      {reg_wr_i, reg_rd_i, go} = '0;
      reg_addr_i = '0;
      reg_wdata_i = '0;
      wake_src_i = '0;
      repeat (10) @(posedge clk_i);
      reset_n_i <= 1'b1;
      t_regs;
      t_refuse;
      t_idle;
      t_noise;
      t_pdown;
      t_psave;
      t_standby;
      t_reset_wake;
      complete_run;
   end
endmodule // testbench
bind sleep_mode_controller sleep_ctrl_props props (.clk_i, .reset_n_i, .reg_rd_i,
   .reg_rdata_o, .halt_exec_i, .core_hold_o, .resume_irq_o, .resume_reset_o,
   .clk_gates_o, .adc_start_o);
